// File: verilog/serial_device_end.sv
// Operation
// - Serial and virtual port commands run independently
// - Eight data bits, no parity, one stop
// - Transmit line idles high
// - Low start bit, data LSB first
// - Non-inverted levels on both lines
// - Stop bit high at least one period
// - Auto mode measures period from 0xAA
// - Auto detection covers 1200 to 500000 bps
// - Fixed mode accepts 1099 bps to 2 Mbps
// - Source waits 1 ms after reset
// - Transmit only responses or passthrough bytes
// - Virtual port ignores baud mode
// - Speed commands only in host mode
// - Each end times bits from own clock
// - Auto mode ignores bytes until indication
// - Indication byte may lead a packet
// - Full buffer drops data, flags overrun
//
// Device end of the serial port: receiver with rate detection, receive buffer,
// and a transmitter fed by responses or the passthrough input.
// Assumes a 40 MHz clock and an asynchronous source line.
`timescale 1ns/100ps
module serial_device_end
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  serial_link_if.device link,
  input wire logic auto_baud, // Automatic rate mode
  input wire logic [serial_port_pkg::CNT_W-1:0] fixed_bit_cyc, // Fixed period
  input wire logic reload, // Settings reload pulse
  input wire logic host_mode, // Host command input mode
  input wire logic usb_valid, // Virtual port byte strobe
  input wire logic [7:0] usb_data,
  output logic usb_cmd_valid, // Virtual port byte out
  output logic [7:0] usb_cmd_data,
  output logic cmd_valid, // Serial command byte available
  input wire logic cmd_ready,
  output logic [7:0] cmd_data,
  output logic speed_allow, // Speed commands permitted
  input wire logic resp_valid, // Response byte offered
  output logic resp_ready,
  input wire logic [7:0] resp_data,
  input wire logic pass_valid, // Passthrough byte offered
  output logic pass_ready,
  input wire logic [7:0] pass_data,
  output logic overrun, // Sticky overrun flag
  input wire logic overrun_clr,
  output logic locked, // Rate known, serial accepted
  output logic [serial_port_pkg::CNT_W-1:0] bit_cyc // Period in use
);
  import serial_port_pkg::*;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_STOP, R_MEAS} rx_state_t;
  typedef enum logic [1:0] {T_IDLE, T_START, T_DATA, T_STOP} tx_state_t;

  // Three-stage synchroniser; the first stage feeds only the second
  logic [2:0] sync_q;
  logic line_q; // Filtered line level
  wire line_agree = sync_q[1] == sync_q[2];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= SYNC_RESET;
      line_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], link.to_dev};
      if (line_agree) line_q <= sync_q[2];
    end
  end
  logic line_d1_q; // Previous filtered level for edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) line_d1_q <= 1'b1;
    else line_d1_q <= line_q;
  end
  wire fall = line_d1_q && !line_q;
  wire rise = !line_d1_q && line_q;

  // Receiver
  rx_state_t rs_q;
  logic [CNT_W-1:0] rcnt_q; // Bit timer
  logic [2:0] ridx_q; // Data bit index
  logic [7:0] rsh_q; // Shift register
  logic [CNT_W-1:0] per_q; // Locked period
  logic lock_q; // Period locked
  logic [3:0] edges_q; // Edges counted in measurement
  logic [CNT_W+2:0] meas_q; // Span of eight bit times
  logic byte_done_q; // Good character strobe
  wire [CNT_W-1:0] cur_per = auto_baud ? per_q : fixed_bit_cyc;
  wire [CNT_W-1:0] half_per = {1'b0, cur_per[CNT_W-1:1]};
  wire rcnt_end = rcnt_q == '0;
  // Auto mode measures; fixed mode is always ready
  wire need_meas = auto_baud && !lock_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs_q <= R_IDLE;
      rcnt_q <= '0;
      ridx_q <= '0;
      rsh_q <= '0;
      per_q <= DEFAULT_BIT_CYC;
      lock_q <= 1'b0;
      edges_q <= '0;
      meas_q <= '0;
      byte_done_q <= 1'b0;
    end else begin
      byte_done_q <= 1'b0;
      if (reload) lock_q <= 1'b0;
      case (rs_q)
        R_IDLE: begin
          if (fall && need_meas) begin
            rs_q <= R_MEAS;
            edges_q <= '0;
            meas_q <= (CNT_W+3)'(1); // Fall cycle counts as the first
          end else if (fall) begin
            rs_q <= R_START;
            rcnt_q <= half_per;
          end
        end
        R_MEAS: begin
          // 0xAA: start falls, then seven edges; the last rise opens bit 7
          meas_q <= meas_q + 1'b1;
          if (fall || rise) edges_q <= edges_q + 1'b1;
          if (rise && edges_q == 4'h6) begin
            // That rise lies eight bit times after the start fall
            per_q <= meas_q[CNT_W+2:3];
            lock_q <= 1'b1;
            rs_q <= R_IDLE;
          end else if (&meas_q) begin
            // Saturation only, so the slowest rate still fits
            rs_q <= R_IDLE; // Too slow to be a valid rate
          end
        end
        R_START: begin
          if (rcnt_end) begin
            if (line_q) rs_q <= R_IDLE; // Glitch, not a start bit
            else begin
              rs_q <= R_DATA;
              rcnt_q <= cur_per - 1'b1;
              ridx_q <= '0;
            end
          end else rcnt_q <= rcnt_q - 1'b1;
        end
        R_DATA: begin
          if (rcnt_end) begin
            rsh_q <= {line_q, rsh_q[7:1]};
            rcnt_q <= cur_per - 1'b1;
            ridx_q <= ridx_q + 1'b1;
            if (ridx_q == 3'h7) rs_q <= R_STOP;
          end else rcnt_q <= rcnt_q - 1'b1;
        end
        R_STOP: begin
          if (rcnt_end) begin
            rs_q <= R_IDLE;
            byte_done_q <= line_q; // Framing error drops the byte
          end else rcnt_q <= rcnt_q - 1'b1;
        end
        default: rs_q <= R_IDLE;
      endcase
    end
  end

  // Receive buffer; a full buffer drops the byte
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_byte_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(byte_done_q),
    .in_ready(fifo_in_ready),
    .in_data(rsh_q),
    .out_valid(fifo_out_valid),
    .out_ready(cmd_ready && cmd_valid),
    .out_data(fifo_out_data)
  );
  logic ov_q; // Overrun sticky flag
  logic cv_q; // Output byte held
  logic [7:0] cd_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ov_q <= 1'b0;
    end else if (byte_done_q && !fifo_in_ready) begin
      ov_q <= 1'b1; // Set wins over clear
    end else if (overrun_clr) begin
      ov_q <= 1'b0;
    end
  end
  // Registered command output stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cv_q <= 1'b0;
      cd_q <= '0;
    end else if (!cv_q || cmd_ready) begin
      cv_q <= 1'b0;
      if (fifo_out_valid && !cv_q) begin
        cv_q <= 1'b1;
        cd_q <= fifo_out_data;
      end
    end
  end
  assign cmd_valid = cv_q;
  assign cmd_data = cd_q;

  // Virtual port path bypasses rate logic
  logic uv_q;
  logic [7:0] ud_q;
  logic sa_q;
  logic [CNT_W-1:0] bc_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uv_q <= 1'b0;
      ud_q <= '0;
      sa_q <= 1'b0;
      bc_q <= '0;
    end else begin
      uv_q <= usb_valid;
      ud_q <= usb_data;
      sa_q <= host_mode;
      bc_q <= cur_per;
    end
  end
  assign usb_cmd_valid = uv_q;
  assign usb_cmd_data = ud_q;
  assign speed_allow = sa_q;
  assign bit_cyc = bc_q;
  assign overrun = ov_q;
  assign locked = lock_q || !auto_baud ? 1'b1 : 1'b0;

  // Transmitter: responses first, then passthrough
  tx_state_t ts_q;
  logic [CNT_W-1:0] tcnt_q;
  logic [2:0] tidx_q;
  logic [7:0] tsh_q;
  logic tx_q; // Line register
  wire tx_idle = ts_q == T_IDLE;
  wire pick_resp = tx_idle && resp_valid;
  wire pick_pass = tx_idle && !resp_valid && pass_valid;
  assign resp_ready = pick_resp;
  assign pass_ready = pick_pass;
  wire tend = tcnt_q == '0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ts_q <= T_IDLE;
      tcnt_q <= '0;
      tidx_q <= '0;
      tsh_q <= '0;
      tx_q <= 1'b1;
    end else begin
      case (ts_q)
        T_IDLE: begin
          tx_q <= 1'b1;
          if (pick_resp || pick_pass) begin
            tsh_q <= pick_resp ? resp_data : pass_data;
            ts_q <= T_START;
            tx_q <= 1'b0;
            tcnt_q <= cur_per - 1'b1;
          end
        end
        T_START: begin
          if (tend) begin
            ts_q <= T_DATA;
            tx_q <= tsh_q[0];
            tidx_q <= '0;
            tcnt_q <= cur_per - 1'b1;
          end else tcnt_q <= tcnt_q - 1'b1;
        end
        T_DATA: begin
          if (tend) begin
            tcnt_q <= cur_per - 1'b1;
            if (tidx_q == 3'h7) begin
              ts_q <= T_STOP;
              tx_q <= 1'b1;
            end else begin
              tidx_q <= tidx_q + 1'b1;
              tsh_q <= {1'b0, tsh_q[7:1]};
              tx_q <= tsh_q[1];
            end
          end else tcnt_q <= tcnt_q - 1'b1;
        end
        T_STOP: begin
          if (tend) ts_q <= T_IDLE; // Full stop period elapsed
          else tcnt_q <= tcnt_q - 1'b1;
        end
        default: ts_q <= T_IDLE;
      endcase
    end
  end
  assign link.to_src = tx_q;
endmodule // serial_device_end

// File: verilog/serial_port_pkg.sv
// Shared constants for the logic-level serial command port and its source.
// Assumes a single 40 MHz clock shared by both ends.
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 40000000; // System clock rate
  localparam int unsigned DATA_BITS = 8; // Eight data bits per character
  localparam logic [7:0] INDICATION_BYTE = 8'haa; // Rate indication value
  localparam int unsigned AUTO_MIN_BPS = 1200; // Slowest detectable rate
  localparam int unsigned AUTO_MAX_BPS = 500000; // Fastest detectable rate
  localparam int unsigned FIXED_MIN_BPS = 1099; // Slowest fixed rate
  localparam int unsigned FIXED_MAX_BPS = 2000000; // Fastest fixed rate
  // Longest bit period in cycles, rounded down; fits the fixed 16-bit counters
  localparam int unsigned MAX_BIT_CYC = CLK_HZ / FIXED_MIN_BPS;
  localparam int unsigned MIN_BIT_CYC = CLK_HZ / FIXED_MAX_BPS; // Shortest bit
  localparam int unsigned CNT_W = 16; // Bit timer width
  localparam logic [CNT_W-1:0] DEFAULT_BIT_CYC = 16'h015b; // 115200 bps
  localparam int unsigned STARTUP_US = 1000; // Source quiet time after reset
  localparam int unsigned STARTUP_CYC = STARTUP_US * (CLK_HZ / 1000000);
  localparam int unsigned FIFO_DEPTH = 16; // Receive buffer depth
  localparam logic [2:0] SYNC_RESET = 3'h7; // Line idles high
endpackage

// File: verilog/serial_link_if.sv
// Two wires between the port and the external serial source.
// Assumes the testbench instantiates it and joins both ends.
`timescale 1ns/100ps
interface serial_link_if;
  logic to_dev; // Source to device line
  logic to_src; // Device to source line
  modport device (input to_dev, output to_src);
  modport source (output to_dev, input to_src);
endinterface

// File: verilog/byte_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; reads are first-word fall-through.
`timescale 1ns/100ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage entries
  logic [AW-1:0] wr_q; // Write index
  logic [AW-1:0] rd_q; // Read index
  logic [AW:0] cnt_q; // Occupancy
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q < (AW+1)'(DEPTH); // Full only at DEPTH entries
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  // Storage written only on push, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // Pointers and count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// File: verilog/serial_source_end.sv
// External source end: waits out the start-up time, then sends bytes
// 8-N-1 at its own rate and receives the device's answers.
// Assumes one 40 MHz clock and the shared link interface.
`timescale 1ns/100ps
module serial_source_end
  import serial_port_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  serial_link_if.source link,
  input wire logic [serial_port_pkg::CNT_W-1:0] bit_cycles, // Own period
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [7:0] send_data,
  output logic recv_valid, // One-cycle pulse
  output logic [7:0] recv_data
);
  import serial_port_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_BITS, S_STOP} src_state_t;
  typedef enum logic [1:0] {W_IDLE, W_BITS, W_STOP} rcv_state_t;
  logic [31:0] wait_q; // Start-up quiet counter
  wire ready_time = wait_q >= STARTUP_CYCLES;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) wait_q <= '0;
    else if (!ready_time) wait_q <= wait_q + 1'b1;
  end
  // Transmit: 9 bits (start + data) then stop
  src_state_t st_q;
  logic [8:0] sh_q;
  logic [3:0] n_q;
  logic [CNT_W-1:0] c_q;
  logic tx_q;
  wire go = st_q == S_IDLE && ready_time && send_valid;
  assign send_ready = go;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      sh_q <= '0;
      n_q <= '0;
      c_q <= '0;
      tx_q <= 1'b1;
    end else begin
      case (st_q)
        S_IDLE: if (go) begin
          sh_q <= {send_data, 1'b0};
          st_q <= S_BITS;
          n_q <= '0;
          c_q <= bit_cycles - 1'b1;
          tx_q <= 1'b0;
        end
        S_BITS: if (c_q == '0) begin
          c_q <= bit_cycles - 1'b1;
          if (n_q == 4'h8) begin
            st_q <= S_STOP;
            tx_q <= 1'b1;
          end else begin
            n_q <= n_q + 1'b1;
            tx_q <= sh_q[n_q + 1'b1];
          end
        end else c_q <= c_q - 1'b1;
        S_STOP: if (c_q == '0) st_q <= S_IDLE;
        else c_q <= c_q - 1'b1;
        default: st_q <= S_IDLE;
      endcase
    end
  end
  assign link.to_dev = tx_q;
  // Receive with three-stage synchroniser, mid-bit sampling
  logic [2:0] sy_q;
  logic ln_q;
  rcv_state_t rs_q; // Receive state
  logic [CNT_W-1:0] rc_q;
  logic [3:0] rn_q;
  logic [7:0] rd_q;
  logic rv_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy_q <= SYNC_RESET;
      ln_q <= 1'b1;
      rs_q <= W_IDLE;
      rc_q <= '0;
      rn_q <= '0;
      rd_q <= '0;
      rv_q <= 1'b0;
    end else begin
      sy_q <= {sy_q[1:0], link.to_src};
      if (sy_q[1] == sy_q[2]) ln_q <= sy_q[2];
      rv_q <= 1'b0;
      case (rs_q)
        W_IDLE: if (!ln_q) begin
          rs_q <= W_BITS;
          rc_q <= bit_cycles + {1'b0, bit_cycles[CNT_W-1:1]};
          rn_q <= '0;
        end
        W_BITS: if (rc_q == '0) begin
          rd_q <= {ln_q, rd_q[7:1]};
          rc_q <= bit_cycles - 1'b1;
          rn_q <= rn_q + 1'b1;
          if (rn_q == 4'h7) rs_q <= W_STOP;
        end else rc_q <= rc_q - 1'b1;
        W_STOP: if (rc_q == '0) begin
          rs_q <= W_IDLE;
          rv_q <= ln_q;
        end else rc_q <= rc_q - 1'b1;
        default: rs_q <= W_IDLE;
      endcase
    end
  end
  assign recv_valid = rv_q;
  assign recv_data = rd_q;
endmodule // serial_source_end

// File: test/serial_link_properties.sv
// Line-level checks on the two serial wires between device and source ends.
// Assumes one clock, nrst active low, and both ends running BIT_CYC per bit.
`timescale 1ns/100ps
module serial_link_properties #(
  parameter int BIT_CYC = 80,
  parameter int STARTUP_CYCLES = 50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic to_dev,
  input wire logic to_src
);
  localparam int FRAME = 10 * BIT_CYC; // Start, eight data, stop
  logic [1:0] line; // Bit 0 source line, bit 1 device line
  logic [1:0] prev_q; // Last sampled levels
  logic [1:0] busy_q; // Frame in progress per line
  logic [15:0] cnt_q [2]; // Cycles since start fall
  logic [15:0] up_q; // Cycles since reset release
  assign line = {to_src, to_dev};
  // Frame tracker; a fall while idle opens a frame, so stray lows are caught too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 2'h3;
      busy_q <= 2'h0;
      cnt_q[0] <= 16'h0000;
      cnt_q[1] <= 16'h0000;
    end else begin
      prev_q <= line;
      for (int i = 0; i < 2; i++) begin
        if (!busy_q[i]) begin
          busy_q[i] <= prev_q[i] & ~line[i];
          cnt_q[i] <= 16'h0001;
        end else if (cnt_q[i] == 16'(FRAME - 1)) begin
          busy_q[i] <= 1'b0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end
  end
  // Saturating age counter, avoids wrap after long runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up_q <= 16'h0000;
    end else if (up_q != 16'hffff) begin
      up_q <= up_q + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence src_start;
    !busy_q[0] && prev_q[0] && !to_dev;
  endsequence
  sequence dev_start;
    !busy_q[1] && prev_q[1] && !to_src;
  endsequence
  chk_src_start_low: assert property (
    busy_q[0] && cnt_q[0] < 16'(BIT_CYC) |-> !to_dev) else $error("Source start bit short");
  chk_dev_start_low: assert property (
    busy_q[1] && cnt_q[1] < 16'(BIT_CYC) |-> !to_src) else $error("Device start bit short");
  chk_src_stop_high: assert property (
    busy_q[0] && cnt_q[0] >= 16'(9 * BIT_CYC) |-> to_dev) else $error("Source stop bit low");
  chk_dev_stop_high: assert property (
    busy_q[1] && cnt_q[1] >= 16'(9 * BIT_CYC) |-> to_src) else $error("Device stop bit low");
  chk_src_bit_steady: assert property (
    busy_q[0] && (cnt_q[0] % 16'(BIT_CYC)) != 16'h0000 |-> $stable(to_dev))
    else $error("Source line moved inside a bit");
  chk_dev_bit_steady: assert property (
    busy_q[1] && (cnt_q[1] % 16'(BIT_CYC)) != 16'h0000 |-> $stable(to_src))
    else $error("Device line moved inside a bit");
  chk_startup_quiet: assert property (
    up_q + 16'h0001 < 16'(STARTUP_CYCLES) |-> to_dev) else $error("Source sent too early");
  chk_idle_after_reset: assert property (
    $rose(nrst) |-> (to_dev && to_src) [*4]) else $error("Line not idle high after reset");
  chk_src_start_held: assert property (
    src_start |=> (!to_dev) [*8]) else $error("Source start glitch");
  chk_dev_start_held: assert property (
    dev_start |=> (!to_src) [*8]) else $error("Device start glitch");
endmodule // serial_link_properties

// File: test/ttl_serial_autobaud_port_tb.sv
// Bench joining device and source ends through the link interface.
// Assumes the package constants and a 40 MHz clock; inputs move at falling edges.
`timescale 1ns/100ps
module ttl_serial_autobaud_port_tb;
  import serial_port_pkg::*;
  localparam int P = 80; // 500 kbps, fastest detectable rate
  localparam int QUIET = 50; // Shortened source start-up wait
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic auto_baud = 1'b1, reload = 1'b0, host_mode = 1'b0, usb_valid = 1'b0;
  logic cmd_ready = 1'b1, resp_valid = 1'b0, pass_valid = 1'b0, overrun_clr = 1'b0;
  logic send_valid = 1'b0;
  logic [7:0] usb_data = 8'h00, resp_data = 8'h00, pass_data = 8'h00, send_data = 8'h00;
  logic [CNT_W-1:0] fixed_bit_cyc = 16'h0100; // Changed before fixed mode is used
  logic [CNT_W-1:0] bit_cycles = 16'(P); // Source's own period
  logic usb_cmd_valid, cmd_valid, speed_allow, resp_ready, pass_ready, overrun, locked;
  logic send_ready, recv_valid;
  logic [7:0] usb_cmd_data, cmd_data, recv_data;
  logic [CNT_W-1:0] bit_cyc;
  int errors = 0;
  int n_checks = 0;
  logic [7:0] q_cmd[$], q_rx[$], q_usb[$]; // Expected bytes per output
  serial_link_if lnk ();
  serial_device_end i_serial_device_end (.clk(clk), .nrst(nrst), .link(lnk),
    .auto_baud(auto_baud), .fixed_bit_cyc(fixed_bit_cyc), .reload(reload),
    .host_mode(host_mode), .usb_valid(usb_valid), .usb_data(usb_data),
    .usb_cmd_valid(usb_cmd_valid), .usb_cmd_data(usb_cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .speed_allow(speed_allow),
    .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_data(resp_data),
    .pass_valid(pass_valid), .pass_ready(pass_ready), .pass_data(pass_data),
    .overrun(overrun), .overrun_clr(overrun_clr), .locked(locked), .bit_cyc(bit_cyc));
  serial_source_end #(.STARTUP_CYCLES(QUIET)) i_serial_source_end (.clk(clk),
    .nrst(nrst), .link(lnk), .bit_cycles(bit_cycles), .send_valid(send_valid),
    .send_ready(send_ready), .send_data(send_data), .recv_valid(recv_valid),
    .recv_data(recv_data));
  serial_link_properties #(.BIT_CYC(P), .STARTUP_CYCLES(QUIET)) i_serial_link_properties (
    .clk(clk), .nrst(nrst), .to_dev(lnk.to_dev), .to_src(lnk.to_src));
  // Free-running system clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Pop the oldest note and compare; an empty queue means an unexpected byte
  task automatic pop_chk(ref logic [7:0] q[$], input logic [7:0] got);
    logic [7:0] want;
    want = 8'h00;
    if (q.size() == 0) begin
      errors++;
      $display("Error at %0t: unexpected byte %h", $time, got);
    end else begin
      // Pop once; the macro names its operands twice
      want = q.pop_front();
      `CHK(got, want)
    end
  endtask
  // Result watcher; settles 1 ns past the falling edge so inputs are final
  always @(negedge clk) begin
    #1;
    if (nrst && cmd_valid && cmd_ready) pop_chk(q_cmd, cmd_data);
    if (nrst && recv_valid) pop_chk(q_rx, recv_data);
    if (nrst && usb_cmd_valid) pop_chk(q_usb, usb_cmd_data);
  end
  // Hand one byte to the source; hold until taken
  task send_src(input logic [7:0] d, input bit expect_it);
    @(negedge clk);
    send_valid = 1'b1;
    send_data = d;
    #1;
    while (send_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    if (expect_it) q_cmd.push_back(d);
    @(negedge clk);
    send_valid = 1'b0;
  endtask
  // Offer a response and a passthrough byte together; response must win
  task offer_tx(input logic [7:0] r, input logic [7:0] p);
    logic tr, tp;
    @(negedge clk);
    resp_valid = 1'b1;
    resp_data = r;
    pass_valid = 1'b1;
    pass_data = p;
    q_rx.push_back(r);
    q_rx.push_back(p);
    while (resp_valid || pass_valid) begin
      #1;
      tr = resp_valid & resp_ready;
      tp = !tr & pass_valid & pass_ready;
      if (tr) `CHK(pass_ready, 1'b0)
      @(negedge clk);
      if (tr) resp_valid = 1'b0;
      if (tp) pass_valid = 1'b0;
    end
  endtask
  // Virtual port byte, one-cycle strobe
  task usb_put(input logic [7:0] d);
    @(negedge clk);
    usb_valid = 1'b1;
    usb_data = d;
    q_usb.push_back(d);
    @(negedge clk);
    usb_valid = 1'b0;
  endtask
  // Sample the source line mid-bit: start, data LSB first, stop
  task line_watch(input logic [7:0] d);
    logic [9:0] frame;
    frame = {1'b1, d, 1'b0};
    @(negedge lnk.to_dev);
    repeat (P / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      `CHK(lnk.to_dev, frame[i])
      repeat (P) @(posedge clk);
    end
  endtask
  // One frame plus margin, fixed by the character length
  task settle();
    repeat (12 * P) @(negedge clk);
  endtask
  // By reference, so the level reaches the design while the task runs
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task results();
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [7:0] d;
    void'($urandom(32'h2642));
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    `CHK(lnk.to_src, 1'b1)
    repeat (2) @(negedge clk);
    `CHK(locked, 1'b0)
    `CHK(bit_cyc, DEFAULT_BIT_CYC)
    send_src(INDICATION_BYTE, 0); // Offered at once, source must wait
    settle();
    `CHK(locked, 1'b1)
    `CHK(bit_cyc, 16'(P))
    d = 8'($urandom);
    fork
      send_src(d, 1);
      line_watch(d);
      for (int i = 0; i < 6; i++) usb_put(8'($urandom));
    join
    send_src(8'h00, 1);
    send_src(8'hff, 1);
    send_src(INDICATION_BYTE, 1);
    for (int i = 0; i < 3; i++) send_src(8'($urandom), 1);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      host_mode = ~host_mode;
      @(negedge clk);
      `CHK(speed_allow, host_mode)
    end
    for (int i = 0; i < 2; i++) offer_tx(8'($urandom), 8'($urandom));
    settle();
    `CHK(lnk.to_src, 1'b1)
    @(negedge clk);
    cmd_ready = 1'b0;
    for (int i = 0; i < 17; i++) send_src(8'($urandom), i < 16);
    settle();
    `CHK(overrun, 1'b1)
    @(negedge clk);
    cmd_ready = 1'b1;
    repeat (40) @(negedge clk);
    `CHK(q_cmd.size() == 0, 1'b1)
    pulse(overrun_clr);
    `CHK(overrun, 1'b0)
    pulse(reload);
    `CHK(locked, 1'b0)
    send_src(INDICATION_BYTE, 0); // Leading byte of a packet
    send_src(8'h81, 1);
    settle();
    `CHK(locked, 1'b1)
    @(negedge clk);
    auto_baud = 1'b0;
    fixed_bit_cyc = 16'(P);
    pulse(reload);
    `CHK(locked, 1'b1)
    `CHK(bit_cyc, 16'(P))
    send_src(8'($urandom), 1);
    settle();
    `CHK(q_cmd.size() + q_rx.size() + q_usb.size() == 0, 1'b1)
    results();
  end
  // Watchdog, well past the expected run of about 26000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    results();
  end
endmodule // ttl_serial_autobaud_port_tb
